// ---- gfs_pkg.sv ----
// Constants, register map and types of the gating fault supervisor.
// Assumes a 20 MHz system clock; all long timings are counted in millisecond ticks.
package gfs_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / MS_PER_S;
  localparam int unsigned TW             = 22;

  // Documented times in their own units, then as millisecond counts
  localparam real         T_RES_HOLD_MIN = 2.5;
  localparam real         T_INTR_FAST_S  = 2.0;
  localparam real         T_INTR_STD_S   = 4.0;
  localparam real         T_PMODE_H      = 1.0;
  localparam real         T_OVR_OFF_S    = 120.0;
  localparam real         T_OVR_LOCK_S   = 150.0;
  localparam real         T_SIMUL_S      = 0.5;
  localparam real         T_SYNC_MIN     = 1.0;
  localparam real         T_BLINK_HZ     = 1.0;
  localparam int unsigned RES_HOLD_MS    = int'(T_RES_HOLD_MIN * 60.0 * 1000.0);
  localparam int unsigned INTR_FAST_MS   = int'(T_INTR_FAST_S * 1000.0);
  localparam int unsigned INTR_STD_MS    = int'(T_INTR_STD_S * 1000.0);
  localparam int unsigned PMODE_MS       = int'(T_PMODE_H * 3600.0 * 1000.0);
  localparam int unsigned OVR_OFF_MS     = int'(T_OVR_OFF_S * 1000.0);
  localparam int unsigned OVR_LOCK_MS    = int'(T_OVR_LOCK_S * 1000.0);
  localparam int unsigned SIMUL_MS       = int'(T_SIMUL_S * 1000.0);
  localparam int unsigned SYNC_MS        = int'(T_SYNC_MIN * 60.0 * 1000.0);
  localparam int unsigned BLINK_HALF_MS  = int'(1000.0 / (2.0 * T_BLINK_HZ));

  // Register map (byte addresses)
  localparam logic [7:0]  ADR_CTRL       = 8'h00;
  localparam logic [7:0]  ADR_STATUS     = 8'h04;
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_PMODE_BIT = 3;
  localparam int unsigned CTRL_LINE_LSB  = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0005;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_007f;
  localparam int unsigned ST_CODE_LSB    = 0;
  localparam int unsigned ST_CAT_LSB     = 8;
  localparam int unsigned ST_LOCK_BIT    = 10;
  localparam int unsigned ST_OUT_A_BIT   = 11;
  localparam int unsigned ST_OUT_B_BIT   = 12;
  localparam int unsigned ST_RED_BIT     = 13;
  localparam int unsigned ST_STATE_LSB   = 16;

  // Gating operating modes
  localparam logic [2:0]  MODE_QSTOP     = 3'h1;
  localparam logic [2:0]  MODE_SHORT     = 3'h4;
  localparam logic [2:0]  MODE_PARTIAL   = 3'h6;

  // Code category prefixes
  localparam logic [1:0]  CAT_NONE       = 2'h0;
  localparam logic [1:0]  CAT_INTERNAL   = 2'h1;
  localparam logic [1:0]  CAT_EXTERNAL   = 2'h2;
  localparam logic [1:0]  CAT_USAGE      = 2'h3;

  // External error code numbers
  localparam int unsigned NUM_CODES      = 80;
  localparam int unsigned ERR_OUT_BASE   = 3;
  localparam int unsigned NUM_OUT_FAULTS = 9;
  localparam int unsigned ERR_UNDERV     = 14;
  localparam int unsigned ERR_OVERV      = 15;
  localparam int unsigned ERR_OVERV_HI   = 16;
  localparam int unsigned ERR_TEMP_HI    = 18;
  localparam int unsigned ERR_TEMP_LO    = 19;
  localparam int unsigned ERR_LINE_BASE  = 22;
  localparam int unsigned NUM_LINES      = 3;
  localparam int unsigned ERR_RES_STUCK  = 39;
  localparam int unsigned ERR_POLARITY   = 41;
  localparam int unsigned ERR_BEAM_CFG   = 60;
  localparam int unsigned ERR_RESP_TIME  = 61;
  localparam int unsigned ERR_BLANK_OVL  = 62;
  localparam int unsigned ERR_LATE_INTR  = 64;
  localparam int unsigned ERR_PMODE_TO   = 65;
  localparam int unsigned ERR_START_DROP = 66;
  localparam int unsigned ERR_HOLD_DROP  = 67;
  localparam int unsigned ERR_OVR_TO     = 68;
  localparam int unsigned ERR_SIMUL      = 69;
  localparam int unsigned ERR_FIELD_LOST = 70;
  localparam int unsigned ERR_EARLY_FLD  = 71;
  localparam int unsigned ERR_ANTIV_END  = 72;
  localparam int unsigned ERR_ANTIV_STOP = 73;
  localparam int unsigned ERR_START_LOCK = 74;

  // Supervisor states, one-hot
  typedef enum logic [5:0] {
    ST_RUN   = 6'h01,
    ST_ARMED = 6'h02,
    ST_GATE  = 6'h04,
    ST_END   = 6'h08,
    ST_OFF   = 6'h10,
    ST_LOCK  = 6'h20
  } gfs_state_t;

endpackage

// ---- gfs_timer.sv ----
// Millisecond timer used by the gating fault supervisor.
// Assumes a one-cycle tick per millisecond from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module gfs_timer
  import gfs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          run,
  output logic [TW-1:0]      count
);
  logic [TW-1:0] count_reg;
  logic [TW-1:0] count_next;

  // Clears while idle, saturates so a held condition never wraps back to zero
  always_comb
  begin
    count_next = count_reg;
    if (!run)
      count_next = '0;
    else if (tick && (count_reg != {TW{1'b1}}))
      count_next = count_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      count_reg <= '0;
    else if (ce)
      count_reg <= count_next;
  end

  assign count = count_reg;
endmodule // gfs_timer
`default_nettype wire

// ---- gfs_supervisor.sv ----
// Gating fault supervisor: detector flags, gating sequence checks, code latch,
// safety output control and a classic Wishbone register slave.
// Assumes all pin inputs are asynchronous to clk; one clock, synchronous reset.
// Behaviour
// - Any output-stage fault flag: report its code, outputs off, no locking.
// - Undervoltage or overvoltage: code and outputs off; severe overvoltage locks.
// - Temperature too high or low: code and outputs off.
// - Signal line read-back mismatch or joint switching: line code, outputs off.
// - Restart button held beyond 2.5 min: stuck code, outputs off.
// - Supply polarity reversal changing mode: code and locking.
// - Beam configuration, response time, blanking overlap faults: own codes, outputs off.
// - Field not interrupted within 2 s or 4 s of start: off, reset needed.
// - Protective mode: 1 h without violation and start still high: off, reset.
// - Start input dropping during override before field clear: code, outputs off.
// - Modes 1 and 6: hold input dropping during override: code, outputs off.
// - Override over 120 s switches outputs off; over 150 s locks.
// - Modes 1 and 6: start and hold skew over 0.5 s: code, off.
// - Field interrupted in a gating pass and start inactive, or sync beams over 1 min: off.
// - Field violated before sequence reset: code, off, reset needed.
// - Modes 1 and 6: antivalence lost at end or qualified stop: codes, off.
// - Start input high while restart interlock locked: code, outputs stay off.
// - Displayed code carries a category prefix: always external, never internal or usage.
// - External error active: red indicator blinks at about 1 Hz.
`timescale 1ns/1ps
`default_nettype none
module gfs_supervisor
  import gfs_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = TICK_CYCLES,
  parameter int unsigned RES_HOLD    = RES_HOLD_MS,
  parameter int unsigned INTR_FAST   = INTR_FAST_MS,
  parameter int unsigned INTR_STD    = INTR_STD_MS,
  parameter int unsigned PMODE_LIM   = PMODE_MS,
  parameter int unsigned OVR_OFF     = OVR_OFF_MS,
  parameter int unsigned OVR_LOCK    = OVR_LOCK_MS,
  parameter int unsigned SYNC_LIM    = SYNC_MS
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Detector flags and machine-side pins
  input  wire logic [8:0]  out_fault_in,
  input  wire logic        underv_in,
  input  wire logic        overv_in,
  input  wire logic        overv_hi_in,
  input  wire logic        temp_hi_in,
  input  wire logic        temp_lo_in,
  input  wire logic [2:0]  line_rb_in,
  input  wire logic        restart_button_in,
  input  wire logic        polarity_rev_in,
  input  wire logic        beam_cfg_fault_in,
  input  wire logic        resp_time_fault_in,
  input  wire logic        blank_overlap_in,
  input  wire logic        field_int_in,
  input  wire logic        sync_int_in,
  input  wire logic        gating_start_in,
  input  wire logic        gating_hold_in,
  input  wire logic        override_in,
  input  wire logic        qstop_in,
  // Outputs
  output logic [2:0]       line_out,
  output logic             safety_output_a,
  output logic             safety_output_b,
  output logic [1:0]       disp_cat,
  output logic [7:0]       disp_code,
  output logic             led_red,
  output logic             locked
);
  localparam int unsigned PW   = 28;
  localparam int unsigned TCW  = $clog2(MS_CYCLES + 1);
  localparam int unsigned NTMR = 5;
  localparam int unsigned TM_RES = 0;
  localparam int unsigned TM_INTR = 1;
  localparam int unsigned TM_OVR = 2;
  localparam int unsigned TM_SIMUL = 3;
  localparam int unsigned TM_SYNC = 4;

  // Limit check shared by every timed condition
  function automatic logic t_over(input logic [TW-1:0] c, input int unsigned lim);
    return c > TW'(lim);
  endfunction

  // Lowest set code wins a tie
  function automatic logic [7:0] first_code(input logic [NUM_CODES-1:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NUM_CODES - 1; i >= 0; i--)
      if (d[i])
        r = 8'(i);
    return r;
  endfunction

  gfs_state_t         state_reg, state_next;
  logic [PW-1:0]      sync1_reg, sync2_reg, prev_reg;
  logic [31:0]        ctrl_reg, ctrl_next;
  logic [2:0]         drv_d1_reg, drv_d2_reg;
  logic [TCW-1:0]     tick_cnt_reg, tick_cnt_next;
  logic               tick;
  logic [8:0]         blink_cnt_reg, blink_cnt_next;
  logic               blink_reg, blink_next;
  logic [7:0]         code_reg, code_next;
  logic               out_reg, out_next;
  logic               ack_reg, ack_next;
  logic [31:0]        rdat_reg, rdat_next;
  logic [NUM_CODES-1:0] det;
  logic               any_det, lock_det;
  logic [NTMR-1:0]    run;
  logic [TW-1:0]      cnt [NTMR];

  // Unpacked, synchronised pins
  logic [8:0] fault_s;
  logic [2:0] rb_s, rb_edge;
  logic uv_s, ov_s, ovh_s, thi_s, tlo_s, res_s, pol_s, beam_s, resp_s, blank_s;
  logic fld_s, snc_s, gs_s, gh_s, ovr_s, qs_s, res_rel, gs_rise, gs_fall, qs_rise;
  logic [2:0] mode;
  logic       pmode, dual, active;
  logic [31:0] status;

  // Two-stage synchroniser; logic reads the second stage and its one-cycle delayed copy prev_reg
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end
    else if (ce)
    begin
      sync1_reg <= {out_fault_in, underv_in, overv_in, overv_hi_in, temp_hi_in, temp_lo_in,
                    line_rb_in, restart_button_in, polarity_rev_in, beam_cfg_fault_in,
                    resp_time_fault_in, blank_overlap_in, field_int_in, sync_int_in,
                    gating_start_in, gating_hold_in, override_in, qstop_in};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign {fault_s, uv_s, ov_s, ovh_s, thi_s, tlo_s, rb_s, res_s, pol_s, beam_s, resp_s,
          blank_s, fld_s, snc_s, gs_s, gh_s, ovr_s, qs_s} = sync2_reg;
  assign rb_edge = rb_s ^ prev_reg[13:11];
  assign res_rel = prev_reg[10] & ~res_s;
  assign gs_rise = gs_s & ~prev_reg[3];
  assign gs_fall = ~gs_s & prev_reg[3];
  assign qs_rise = qs_s & ~prev_reg[0];
  assign mode    = ctrl_reg[CTRL_MODE_LSB +: 3];
  assign pmode   = ctrl_reg[CTRL_PMODE_BIT];
  assign dual    = (mode == MODE_QSTOP) || (mode == MODE_PARTIAL);
  assign active  = (state_reg == ST_RUN) || (state_reg == ST_ARMED) || (state_reg == ST_GATE);

  // Millisecond tick and 1 Hz blink base
  always_comb
  begin
    tick           = (tick_cnt_reg == TCW'(MS_CYCLES - 1));
    tick_cnt_next  = tick ? '0 : tick_cnt_reg + 1'b1;
    blink_cnt_next = blink_cnt_reg;
    blink_next     = blink_reg;
    if (tick)
    begin
      if (blink_cnt_reg == 9'(BLINK_HALF_MS - 1))
      begin
        blink_cnt_next = '0;
        blink_next     = ~blink_reg;
      end
      else
        blink_cnt_next = blink_cnt_reg + 1'b1;
    end
  end

  // Timer run conditions; each timer clears as soon as its condition goes away
  always_comb
  begin
    run           = '0;
    run[TM_RES]   = res_s;
    run[TM_INTR]  = (state_reg == ST_ARMED);
    // Keeps counting after the off reaction, so the lock limit is still reached
    run[TM_OVR]   = ovr_s && ((state_reg == ST_GATE) ||
                              (code_reg == 8'(ERR_OVR_TO)));
    run[TM_SIMUL] = dual && active && (gs_s != gh_s);
    run[TM_SYNC]  = fld_s && snc_s;
  end

  for (genvar g = 0; g < NTMR; g++)
  begin : g_tmr
    gfs_timer u_tmr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .tick    (tick),
      .run     (run[g]),
      .count   (cnt[g])
    );
  end

  // Fault detection, one bit per code number
  always_comb
  begin
    det = '0;
    for (int i = 0; i < NUM_OUT_FAULTS; i++)
      det[ERR_OUT_BASE + i] = fault_s[i];
    det[ERR_UNDERV]   = uv_s;
    det[ERR_OVERV]    = ov_s;
    det[ERR_OVERV_HI] = ovh_s;
    det[ERR_TEMP_HI]  = thi_s;
    det[ERR_TEMP_LO]  = tlo_s;
    // Drive is delayed to match the synchroniser, so no false mismatch on a change
    for (int i = 0; i < NUM_LINES; i++)
      det[ERR_LINE_BASE + i] = (rb_s[i] != drv_d2_reg[i]) ||
                               (rb_edge[i] && |(rb_edge & ~(3'h1 << i)));
    det[ERR_RES_STUCK] = t_over(cnt[TM_RES], RES_HOLD);
    det[ERR_POLARITY]  = pol_s;
    det[ERR_BEAM_CFG]  = beam_s;
    det[ERR_RESP_TIME] = resp_s;
    det[ERR_BLANK_OVL] = blank_s;
    if (state_reg == ST_ARMED)
    begin
      if (!pmode)
        det[ERR_LATE_INTR] = t_over(cnt[TM_INTR],
                                    (mode == MODE_SHORT) ? INTR_FAST : INTR_STD);
      else
        det[ERR_PMODE_TO] = t_over(cnt[TM_INTR], PMODE_LIM) && gs_s;
    end
    if (state_reg == ST_GATE)
    begin
      det[ERR_START_DROP] = ovr_s && !gs_s;
      det[ERR_HOLD_DROP]  = ovr_s && dual && !gh_s;
      det[ERR_FIELD_LOST] = !ovr_s && !gs_s;
    end
    det[ERR_FIELD_LOST] = det[ERR_FIELD_LOST] || t_over(cnt[TM_SYNC], SYNC_LIM);
    det[ERR_OVR_TO]     = t_over(cnt[TM_OVR], OVR_OFF);
    det[ERR_SIMUL]      = t_over(cnt[TM_SIMUL], SIMUL_MS);
    if (state_reg == ST_END)
    begin
      det[ERR_EARLY_FLD] = fld_s;
      det[ERR_ANTIV_END] = dual && gs_fall && (gs_s == gh_s);
    end
    det[ERR_ANTIV_STOP] = dual && qs_rise && (gs_s == gh_s) &&
                          ((state_reg == ST_ARMED) || (state_reg == ST_GATE));
    det[ERR_START_LOCK] = (state_reg == ST_OFF) && gs_s && (code_reg == 8'h00);
    any_det  = |det;
    lock_det = ovh_s || pol_s || t_over(cnt[TM_OVR], OVR_LOCK);
  end

  // Sequence and reaction state machine; starts with the restart interlock locked
  always_comb
  begin
    state_next = state_reg;
    code_next  = code_reg;
    case (state_reg)
      ST_RUN:
        if (gs_rise)
          state_next = ST_ARMED;
      ST_ARMED:
        if (fld_s)
          state_next = ST_GATE;
        else if (!gs_s)
          state_next = ST_RUN;
      ST_GATE:
        if (!fld_s)
          state_next = ST_END;
      ST_END:
        if (!gs_s)
          state_next = ST_RUN;
      ST_OFF:
        if (res_rel && !any_det)
        begin
          state_next = ST_RUN;
          code_next  = 8'h00;
        end
      ST_LOCK:
        state_next = ST_LOCK;
      default:
        state_next = ST_LOCK;
    endcase
    if (lock_det)
      state_next = ST_LOCK;
    else if (any_det && (state_reg != ST_LOCK))
      state_next = ST_OFF;
    // First code stays shown; a later fault never overwrites it
    if (any_det && (code_reg == 8'h00))
      code_next = first_code(det);
    out_next = (state_next == ST_RUN) || (state_next == ST_ARMED) ||
               (state_next == ST_GATE) || (state_next == ST_END);
  end

  // Register access; ack is registered, so every access answers one cycle later
  always_comb
  begin
    status = '0;
    status[ST_CODE_LSB +: 8]  = code_reg;
    status[ST_CAT_LSB +: 2]   = disp_cat;
    status[ST_LOCK_BIT]       = (state_reg == ST_LOCK);
    status[ST_OUT_A_BIT]      = out_reg;
    status[ST_OUT_B_BIT]      = out_reg;
    status[ST_RED_BIT]        = led_red;
    status[ST_STATE_LSB +: 6] = state_reg;
    ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
    ctrl_next = ctrl_reg;
    rdat_next = rdat_reg;
    if (ack_next)
    begin
      if (wb_adr_i == ADR_CTRL)
        rdat_next = ctrl_reg;
      else if (wb_adr_i == ADR_STATUS)
        rdat_next = status;
      else
        rdat_next = '0;
    end
    // Write lands only at the edge where the master sees ack high
    if (wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && (wb_adr_i == ADR_CTRL))
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          ctrl_next[b*8 +: 8] = wb_dat_i[b*8 +: 8] & CTRL_MASK[b*8 +: 8];
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg     <= ST_OFF;
      code_reg      <= 8'h00;
      out_reg       <= 1'b0;
      ctrl_reg      <= CTRL_RESET;
      ack_reg       <= 1'b0;
      rdat_reg      <= '0;
      tick_cnt_reg  <= '0;
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
      drv_d1_reg    <= '0;
      drv_d2_reg    <= '0;
    end
    else if (ce)
    begin
      state_reg     <= state_next;
      code_reg      <= code_next;
      out_reg       <= out_next;
      ctrl_reg      <= ctrl_next;
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
      tick_cnt_reg  <= tick_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg     <= blink_next;
      drv_d1_reg    <= ctrl_reg[CTRL_LINE_LSB +: 3];
      drv_d2_reg    <= drv_d1_reg;
    end
  end

  // Outputs; only external codes are raised here
  assign line_out        = ctrl_reg[CTRL_LINE_LSB +: 3];
  assign safety_output_a = out_reg;
  assign safety_output_b = out_reg;
  assign disp_code       = code_reg;
  assign disp_cat        = (code_reg != 8'h00) ? CAT_EXTERNAL : CAT_NONE;
  assign led_red         = (code_reg != 8'h00) ? blink_reg : !out_reg;
  assign locked          = (state_reg == ST_LOCK);
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdat_reg;
endmodule // gfs_supervisor
`default_nettype wire

// ---- gfs_assertions.sv ----
// Port-level checker for the gating fault supervisor.
// Assumes one clock domain and a bind onto gfs_supervisor.
`timescale 1ns/1ps
`default_nettype none
module gfs_assertions
  import gfs_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [8:0] out_fault_in,
  input wire logic       overv_hi_in,
  input wire logic       safety_output_a,
  input wire logic       safety_output_b,
  input wire logic [1:0] disp_cat,
  input wire logic [7:0] disp_code,
  input wire logic       locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Causes held long enough to pass the pin synchronisers
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_fault; (|out_fault_in)[*5]; endsequence
  sequence s_sev; overv_hi_in[*4]; endsequence
  outs_same_a: assert property (safety_output_a == safety_output_b)
    else $error("safety outputs differ");
  fault_off_a: assert property (s_fault |-> !safety_output_a)
    else $error("outputs on during output fault");
  sev_lock_a: assert property (s_sev |-> ##[0:2] locked)
    else $error("no lock on severe overvoltage");
  lock_off_a: assert property (locked |-> !safety_output_a)
    else $error("outputs on while locked");
  lock_held_a: assert property (locked |=> locked)
    else $error("lock left without reset");
  cat_ext_a: assert property ((disp_code != 8'h00) == (disp_cat == CAT_EXTERNAL))
    else $error("category prefix wrong");
  code_kept_a: assert property ($changed(disp_code) |->
    $past(disp_code) == 8'h00 || disp_code == 8'h00)
    else $error("shown code replaced");
  ack_pulse_a: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
endmodule // gfs_assertions
bind gfs_supervisor gfs_assertions gfs_assertions_inst (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .out_fault_in(out_fault_in), .overv_hi_in(overv_hi_in), .locked(locked),
  .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
  .disp_cat(disp_cat), .disp_code(disp_code));
`default_nettype wire

// ---- gfs_ctrl_model.sv ----
// Machine controller model: gating inputs, field and restart button.
// Assumes the bench calls its tasks; changes land right after an edge.
`timescale 1ns/1ps
`default_nettype none
module gfs_ctrl_model
(
  input  wire logic clk,
  output var logic  start,
  output var logic  hold,
  output var logic  field,
  output var logic  ovr,
  output var logic  button
);
  initial {start, hold, field, ovr, button} = 5'h00;
  // One level set {start, hold, field, override}, held n cycles
  task automatic step(input logic [3:0] v, input int n);
    @(posedge clk);
    {start, hold, field, ovr} <= v;
    repeat (n) @(posedge clk);
  endtask
  // Short press, well under the stuck limit
  task automatic press(input int n);
    @(posedge clk);
    button <= 1'b1;
    repeat (n) @(posedge clk);
    button <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Full pass; start kept high until the field is clear
  task automatic gate(input int lag, input int ms);
    step(4'h8, lag);
    step(4'ha, 2 * ms);
    step(4'h8, ms);
    step(4'h0, ms);
  endtask
endmodule // gfs_ctrl_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the gating fault supervisor.
// Assumes shortened timing parameters and one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gfs_pkg::*;
;
  localparam int MS = 4, RH = 20, TF = 5, TS = 10, PL = 30, OO = 20, OL = 30, SL = 40;
  logic        clk, sys_rst, cyc, stb, we, ack, ovh, pol, b;
  logic        out_a, led, lck, start, hold, field, ovr, button;
  logic        ce, snc, qs, out_b;
  logic [1:0]  cat;
  logic [3:0]  sel;
  logic [7:0]  adr, code;
  logic [31:0] wdat, rdat, dat_o;
  logic [18:0] fv;
  logic [2:0]  lout;
  int          num_errors, total_checks, i, j, m;
  int          exp_q[$];
  int          cd[19] = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 14, 15, 18, 19, 60, 61, 62, 22, 23, 24};
  gfs_ctrl_model ctl (.clk(clk), .start(start), .hold(hold), .field(field), .ovr(ovr),
    .button(button));
  gfs_supervisor #(.MS_CYCLES(MS), .RES_HOLD(RH), .INTR_FAST(TF), .INTR_STD(TS),
    .PMODE_LIM(PL), .OVR_OFF(OO), .OVR_LOCK(OL), .SYNC_LIM(SL)) gfs_supervisor_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .out_fault_in(fv[8:0]), .underv_in(fv[9]), .overv_in(fv[10]), .overv_hi_in(ovh),
    .temp_hi_in(fv[11]), .temp_lo_in(fv[12]), .line_rb_in(lout ^ fv[18:16]),
    .restart_button_in(button), .polarity_rev_in(pol), .beam_cfg_fault_in(fv[13]),
    .resp_time_fault_in(fv[14]), .blank_overlap_in(fv[15]), .field_int_in(field),
    .sync_int_in(snc), .gating_start_in(start), .gating_hold_in(hold), .override_in(ovr),
    .qstop_in(qs), .line_out(lout), .safety_output_a(out_a), .safety_output_b(out_b),
    .disp_cat(cat), .disp_code(code), .led_red(led), .locked(lck));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Classic single cycle; waits for the answer, no fixed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // Lowest pending code wins when faults coincide
  function automatic int low();
    int q[$];
    q = exp_q.min();
    return (q.size() != 0) ? q[0] : 0;
  endfunction
  task automatic see(input int c);
    repeat (8) @(posedge clk);
    chk("code", {24'h0, code}, c[31:0]);
    chk("out", {31'h0, out_a}, {31'h0, c == 0});
    chk("out b", {31'h0, out_b}, {31'h0, c == 0});
    chk("cat", {30'h0, cat}, (c != 0) ? CAT_EXTERNAL : CAT_NONE);
  endtask
  task automatic clr();
    fv <= '0;
    exp_q.delete();
    ctl.press(3);
    see(0);
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, well past the longest run
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    {cyc, stb, we, adr, wdat, fv, ovh, pol, snc, qs} = '0;
    {ce, sel} = 5'h1f;
    sys_rst = 1'b1;
    void'($urandom(35020));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wb(0, ADR_CTRL, 0);
    chk("ctrl", rdat, CTRL_RESET);
    wb(0, ADR_STATUS, 0);
    chk("status", rdat, 32'h0010_2000);
    wb(0, 8'h08, 0);
    chk("hole", rdat, 0);
    m = 1 << ($urandom % 3);
    wb(1, ADR_CTRL, 32'hffff_ff05 | (m << 4));
    wb(0, ADR_CTRL, 0);
    chk("ctrl rw", rdat, 32'h5 | (m << 4));
    chk("line", {29'h0, lout}, m);
    sel <= 4'h0;
    wb(1, ADR_CTRL, 32'h6);
    sel <= 4'hf;
    wb(0, ADR_CTRL, 0);
    chk("sel", rdat, 32'h5 | (m << 4));
    ctl.step(4'h8, 8);
    see(74);
    // Frozen by the clock enable: a press now must not clear the code
    ce <= 1'b0;
    ctl.step(4'h0, 1);
    ctl.press(3);
    see(74);
    ce <= 1'b1;
    clr();
    // Every non-locking detector flag alone, then random coinciding pairs
    for (i = 0; i < 19; i++)
    begin
      fv[i] <= 1'b1;
      exp_q.push_back(cd[i]);
      see(low());
      clr();
    end
    for (i = 0; i < 4; i++)
    begin
      j = $urandom % 16;
      m = (j + 1 + $urandom % 15) % 16;
      fv[j] <= 1'b1;
      fv[m] <= 1'b1;
      exp_q = '{cd[j], cd[m]};
      see(low());
      clr();
    end
    // Field at 7 ms: late only for the short window
    for (i = 0; i < 2; i++)
    begin
      wb(1, ADR_CTRL, i ? 32'h4 : 32'h5);
      ctl.gate(7 * MS, MS);
      see(i ? 64 : 0);
      if (i) clr();
    end
    for (i = 0; i < 2; i++)
    begin
      ctl.step(4'h8, MS);
      ctl.step(i ? 4'hb : 4'ha, MS);
      ctl.step(i ? 4'h3 : 4'h2, 4 * MS);
      see(i ? 66 : 70);
      ctl.step(4'h0, 1);
      clr();
    end
    // Sync beams held past their limit with the field interrupted
    snc <= 1'b1;
    ctl.step(4'h2, 50 * MS);
    see(70);
    snc <= 1'b0;
    ctl.step(4'h0, 1);
    clr();
    // Protective mode: start held past the timeout with no field
    wb(1, ADR_CTRL, 32'hd);
    ctl.step(4'h8, 40 * MS);
    see(65);
    ctl.step(4'h0, 1);
    clr();
    wb(1, ADR_CTRL, 32'h1);
    ctl.step(4'h4, 600 * MS);
    see(69);
    ctl.step(4'h0, 1);
    clr();
    // Qualified stop with both inputs at the same level
    ctl.step(4'hc, MS);
    qs <= 1'b1;
    see(73);
    qs <= 1'b0;
    ctl.step(4'h0, 1);
    clr();
    ctl.button <= 1'b1;
    repeat (25 * MS) @(posedge clk);
    see(39);
    ctl.button <= 1'b0;
    clr();
    wb(1, ADR_CTRL, 32'h5);
    ctl.step(4'h8, MS);
    ctl.step(4'hb, 25 * MS);
    chk("lock", {31'h0, lck}, 0);
    see(68);
    repeat (10 * MS) @(posedge clk);
    chk("lock", {31'h0, lck}, 1);
    b = led;
    while (led === b) @(posedge clk);
    b = led;
    m = 0;
    while (led === b)
    begin
      @(posedge clk);
      m++;
    end
    chk("blink", m, 500 * MS);
    ctl.step(4'h0, 1);
    rst();
    // Locking causes survive a restart press
    for (i = 0; i < 2; i++)
    begin
      {ovh, pol} <= i ? 2'b01 : 2'b10;
      see(i ? 41 : 16);
      {ovh, pol} <= 2'b00;
      ctl.press(3);
      see(i ? 41 : 16);
      chk("lock", {31'h0, lck}, 1);
      rst();
    end
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
